// *** design/lim_regs.svh ***
// Overview of operation
// - Second latch selector uses first latch code table
// - Third latch selector, top digit, same table
// - Polarity A digit 0 inverts terminal zero
// - Polarity A digit 1 inverts terminal one
// - Polarity A digit 2 inverts terminal two
// - Polarity A digit 3 inverts terminal three
// - Polarity B digit 0 inverts terminal four
// - Codes 0 to 7 route that input, active on
// - Codes B and C hold latch inactive
// - Code D routes input five, active off
`ifndef LIM_REGS_SVH
`define LIM_REGS_SVH

// Register byte addresses
`define LIM_ADDR_LATCH_SELECT 4'h0
`define LIM_ADDR_POL_A 4'h4
`define LIM_ADDR_POL_B 4'h8
`define LIM_ADDR_STATUS 4'hC

// Latch selector digit positions within the select register
`define LIM_SEL_FIRST_LSB 4
`define LIM_SEL_SECOND_LSB 8
`define LIM_SEL_THIRD_LSB 12

// Reset values
`define LIM_LATCH_SELECT_RESET 16'h0000
`define LIM_POL_A_RESET 16'h0000
`define LIM_POL_B_RESET 16'h0000

// Writable bit masks: polarity A low bit of each digit, polarity B low bit of digits 0 and 1 only; select all of its top three digits
`define LIM_POL_A_MASK 16'h1111
`define LIM_POL_B_MASK 16'h0011
`define LIM_LATCH_SELECT_MASK 16'hFFF0

`endif

// *** design/lim_pkg.sv ***
package lim_pkg;
	// Latch source selector code, one hexadecimal digit
	typedef logic [3:0] lim_code_t;
	// Classes of selector code
	typedef enum logic [1:0] {
		lim_route_direct,
		lim_route_inverted,
		lim_route_inactive
	} lim_route_e;
endpackage

// *** design/lim_latch_route.sv ***
`timescale 1ns/1ps
`default_nettype none
module lim_latch_route (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Selector and synchronised input terminals
	input wire logic [3:0] code,
	input wire logic [7:0] inputs,
	// Routed latch signal, active high
	output logic latch
);
	// Decoded route class and the terminal it looks at
	lim_pkg::lim_route_e route;
	logic [2:0] pick;

	// Decode the shared code table
	always_comb begin
		pick = code[2:0];
		if (code[3] == 1'b0) begin
			route = lim_pkg::lim_route_direct;
		end else if (code == 4'hD) begin
			route = lim_pkg::lim_route_inverted;
			pick = 3'h5;
		end else if (code == 4'hE || code == 4'hF) begin
			// Inverted sense of terminals six and seven
			route = lim_pkg::lim_route_inverted;
			pick = {2'h3, code[0]};
		end else begin
			// Codes 8 to C: fixed inactive
			route = lim_pkg::lim_route_inactive;
		end
	end

	// Register the routed level so the output is glitch free
	always_ff @(posedge clk) begin
		if (reset) begin
			latch <= 1'b0;
		end else begin
			case (route)
				lim_pkg::lim_route_direct: latch <= inputs[pick];
				lim_pkg::lim_route_inverted: latch <= ~inputs[pick];
				default: latch <= 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** design/lim_top.sv ***
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "lim_regs.svh"
module lim_top (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Power restart request, one cycle, same clock domain
	input wire logic power_restart,
	// Discrete input terminals from the machine, asynchronous
	input wire logic [7:0] input_terminal,
	// Internal output signals before polarity, same clock domain
	input wire logic [4:0] output_signal,
	// Output terminals towards the machine
	output logic [4:0] output_terminal,
	// Routed external latch signals, active high
	output logic latch_signal_first,
	output logic latch_signal_second,
	output logic latch_signal_third
);
	// Pending settings as software wrote them
	logic [15:0] latch_select;
	logic [15:0] output_polarity_setting_a;
	logic [15:0] output_polarity_setting_b;
	// Live settings used by the routing
	logic [15:0] live_select;
	logic [15:0] live_pol_a;
	logic [15:0] live_pol_b;
	// Two-stage input synchroniser
	logic [7:0] in_meta;
	logic [7:0] in_sync;
	// Live polarity vector for the five terminals
	logic [4:0] invert;
	// Routed latch levels from the selector instances
	logic [2:0] latch_w;

	// Software writes land in the pending copy only
	always_ff @(posedge clk) begin
		if (reset) begin
			latch_select <= `LIM_LATCH_SELECT_RESET;
			output_polarity_setting_a <= `LIM_POL_A_RESET;
			output_polarity_setting_b <= `LIM_POL_B_RESET;
		end else if (wr) begin
			if (addr == `LIM_ADDR_LATCH_SELECT) begin
				latch_select <= wdata[15:0] & `LIM_LATCH_SELECT_MASK;
			end else if (addr == `LIM_ADDR_POL_A) begin
				output_polarity_setting_a <= wdata[15:0] & `LIM_POL_A_MASK;
			end else if (addr == `LIM_ADDR_POL_B) begin
				output_polarity_setting_b <= wdata[15:0] & `LIM_POL_B_MASK;
			end
		end
	end

	// Live copy changes only on a restart, so a half-written set never
	// reaches the terminals while the machine is running
	always_ff @(posedge clk) begin
		if (reset) begin
			live_select <= `LIM_LATCH_SELECT_RESET;
			live_pol_a <= `LIM_POL_A_RESET;
			live_pol_b <= `LIM_POL_B_RESET;
		end else if (power_restart) begin
			live_select <= latch_select;
			live_pol_a <= output_polarity_setting_a;
			live_pol_b <= output_polarity_setting_b;
		end
	end

	// Input terminals are asynchronous: two flops before any use
	always_ff @(posedge clk) begin
		if (reset) begin
			in_meta <= 8'h00;
			in_sync <= 8'h00;
		end else begin
			in_meta <= input_terminal;
			in_sync <= in_meta;
		end
	end

	// Gather the polarity digits into one vector
	always_comb begin
		invert[0] = live_pol_a[0];
		invert[1] = live_pol_a[4];
		invert[2] = live_pol_a[8];
		invert[3] = live_pol_a[12];
		invert[4] = live_pol_b[0];
	end

	// Output terminals: registered, inverted where the digit is 1
	always_ff @(posedge clk) begin
		if (reset) begin
			output_terminal <= 5'h00;
		end else begin
			output_terminal <= output_signal ^ invert;
		end
	end

	// First latch selector, the code table all three share
	lim_latch_route u_first (
		.clk(clk),
		.reset(reset),
		.code(live_select[`LIM_SEL_FIRST_LSB +: 4]),
		.inputs(in_sync),
		.latch(latch_w[0])
	);

	// Second latch selector, same table
	lim_latch_route u_second (
		.clk(clk),
		.reset(reset),
		.code(live_select[`LIM_SEL_SECOND_LSB +: 4]),
		.inputs(in_sync),
		.latch(latch_w[1])
	);

	// Third latch selector in the top digit, same table
	lim_latch_route u_third (
		.clk(clk),
		.reset(reset),
		.code(live_select[`LIM_SEL_THIRD_LSB +: 4]),
		.inputs(in_sync),
		.latch(latch_w[2])
	);

	// Latch outputs come straight from the instances' flops
	always_comb begin
		latch_signal_first = latch_w[0];
		latch_signal_second = latch_w[1];
		latch_signal_third = latch_w[2];
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			if (addr == `LIM_ADDR_LATCH_SELECT) begin
				rdata <= {16'h0000, latch_select};
			end else if (addr == `LIM_ADDR_POL_A) begin
				rdata <= {16'h0000, output_polarity_setting_a};
			end else if (addr == `LIM_ADDR_POL_B) begin
				rdata <= {16'h0000, output_polarity_setting_b};
			end else if (addr == `LIM_ADDR_STATUS) begin
				// Live state: latches, terminals, synchronised inputs
				rdata <= {13'h0000, latch_w, 3'h0, output_terminal, in_sync};
			end else begin
				// Unmapped address reads zero
				rdata <= 32'h0000_0000;
			end
		end else begin
			rdata <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// *** dv/lim_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module lim_top_asserts (
	// Clock, reset and register port
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] addr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	// Restart and terminals
	input wire logic power_restart,
	input wire logic [7:0] input_terminal,
	input wire logic [4:0] output_signal,
	input wire logic [4:0] output_terminal,
	input wire logic latch_signal_first,
	input wire logic latch_signal_second,
	input wire logic latch_signal_third
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// All three latches as one word
	wire logic [2:0] lat = {latch_signal_first, latch_signal_second, latch_signal_third};
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata idle");
	reset_zero_a: assert property ($fell(reset) |-> rdata == 32'h0 && output_terminal == 5'h0
		&& lat == 3'h0) else $error("reset values");
	// Writes alone must never move the live polarity
	pol_hold_a: assert property (
		!$past(reset) && !$past(reset, 2) && !$past(power_restart) && !$past(power_restart, 2)
		|-> (output_terminal ^ $past(output_terminal)) == ($past(output_signal)
		^ $past(output_signal, 2))) else $error("polarity moved");
	latch_hold_a: assert property (
		(!power_restart && $stable(input_terminal))[*5] |=> $stable(lat)) else $error("latch moved");
	sel_mask_a: assert property (rd && addr == 4'h0 |=> (rdata & 32'hFFFF000F) == 32'h0)
		else $error("select mask");
	pola_mask_a: assert property (rd && addr == 4'h4 |=> (rdata & ~32'h1111) == 32'h0)
		else $error("pol a mask");
	polb_mask_a: assert property (rd && addr == 4'h8 |=> (rdata & ~32'h0011) == 32'h0)
		else $error("pol b mask");
	unmapped_a: assert property (rd && !(addr inside {4'h0, 4'h4, 4'h8, 4'hC}) |=> rdata == 32'h0)
		else $error("unmapped read");
	cover property (power_restart);
	cover property (latch_signal_second);
	cover property (rd && addr == 4'h8);
endmodule
bind lim_top lim_top_asserts u_chk (.clk, .reset, .addr, .rd, .rdata, .power_restart,
	.input_terminal, .output_signal, .output_terminal, .latch_signal_first,
	.latch_signal_second, .latch_signal_third);
`default_nettype wire

// *** dv/lim_mach.sv ***
`timescale 1ns/1ps
`default_nettype none
module lim_mach (
	// Clock and requested contact levels
	input wire logic clk,
	input wire logic [7:0] level,
	// Wiring into the drive
	output logic [7:0] input_terminal
);
	// Contacts switch between edges, unrelated to the sampling edge
	// One driver only; the level is unknown until the first falling edge, inside reset
	always @(negedge clk) input_terminal <= level;
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	// Driven inputs, all set at time zero
	logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, power_restart = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [4:0] output_signal = 5'h0;
	logic [7:0] level = 8'h00;
	// Observed outputs
	logic [31:0] rdata;
	logic [7:0] input_terminal;
	logic [4:0] output_terminal;
	logic [2:0] lat;
	int n_fail = 0, n_compared = 0, n_cyc = 0;
	always #12.5 clk = ~clk;
	lim_mach u_mach (.clk, .level, .input_terminal);
	lim_top DUT (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .power_restart, .input_terminal,
		.output_signal, .output_terminal, .latch_signal_first(lat[2]),
		.latch_signal_second(lat[1]), .latch_signal_third(lat[0]));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		n_cyc++;
		if (n_cyc == 2000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic put(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= {16'h0, d};
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic get(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic restart;
		@(posedge clk);
		power_restart <= 1'b1;
		@(posedge clk);
		power_restart <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
	endtask
	// Two sync flops plus the latch flop, with margin
	task automatic sense(input logic [7:0] lv, input logic [2:0] e);
		@(posedge clk);
		level <= lv;
		repeat (6) @(posedge clk);
		#1 chk({29'h0, lat}, {29'h0, e});
	endtask
	// Each digit inverts its own terminal; writes wait for restart
	task automatic t_pol;
		put(4'h8, 16'hFFFF);
		get(4'h8, 16'h0011);
		put(4'h4, 16'hFFFF);
		get(4'h4, 16'h1111);
		put(4'h4, 16'h0101);
		put(4'h8, 16'h0001);
		get(4'h2, 16'h0000);
		@(posedge clk);
		output_signal <= 5'h0A;
		repeat (2) @(posedge clk);
		#1 chk({27'h0, output_terminal}, 32'h0A);
		restart();
		chk({27'h0, output_terminal}, 32'h1F);
		put(4'h4, 16'h1010);
		put(4'h8, 16'h0010);
		restart();
		chk({27'h0, output_terminal}, 32'h00);
	endtask
	// Second and third follow one code; first uses inverted input five
	task automatic t_latch;
		for (int n = 0; n < 8; n++) begin
			put(4'h0, {n[3:0], n[3:0], 8'hDF});
			get(4'h0, {n[3:0], n[3:0], 8'hD0});
			restart();
			sense(8'h01 << n, {n != 5, 2'b11});
			sense(~(8'h01 << n), {n == 5, 2'b00});
		end
		put(4'h0, 16'hBC00);
		restart();
		sense(8'hFF, 3'b100);
		// Status: first latch at bit 16, terminals zero, all inputs on
		get(4'hC, 32'h0001_00FF);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		get(4'h4, 16'h0000);
		t_pol();
		t_latch();
		stop_test();
	end
endmodule
`default_nettype wire
